// ### verilog/vsb_sync_blank.sv
`timescale 1ns/100ps
`include "vsb_map.svh"

// Contract
// - combined blank: h+v composite, v separate
// - combined blank is composite blank after reset
// - composite sync direction from control bit
// - composite sync input yields h and v timing
// - composite sync output: low pulses, external or internal
// - separate mode: composite pin drives horizontal blank
// - composite sync pin is input after reset
// - horizontal sync direction from control bit
// - horizontal sync output: low timer pulse
// - horizontal sync input resyncs at programmable cycle
// - horizontal sync pin is input after reset
// - vertical sync direction bit, low timer pulse
// - vertical sync input resyncs at programmable line
// - vertical sync pin is input after reset
// - video clock drives timing, supplied externally
// - count serial clock, schedule transfer and reload
// - serial clock may be asynchronous
// - external syncs load counters from presets
// - video timing runs on the video clock
module vsb_sync_blank
  import vsb_pkg::*;
#(
  parameter int CNT_W      = 12,
  parameter int VDET_TICKS = 64
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // external clocks
  input  wire logic        videoClock,
  input  wire logic        serialClock,
  // sync pins, enables low while driving
  input  wire logic        hsyncIn,
  output logic             hsyncOut,
  output logic             hsyncOeN,
  input  wire logic        vsyncIn,
  output logic             vsyncOut,
  output logic             vsyncOeN,
  input  wire logic        csyncIn,
  output logic             csyncOut,
  output logic             csyncOeN,
  // blanking and vram scheduling
  output logic             compositeBlank,
  output logic             transferReq,
  output logic             midlineReq
);

  localparam int VD_W = $clog2(VDET_TICKS + 1);

  // horizontal/vertical phase: {sync, blank}
  function automatic logic [1:0] tmgPhase(input logic [CNT_W-1:0] cnt,
                                          input logic [CNT_W-1:0] endSync,
                                          input logic [CNT_W-1:0] endBlank,
                                          input logic [CNT_W-1:0] startBlank);
    tmgPhase = {cnt <= endSync, (cnt > startBlank) || (cnt <= endBlank)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  vsb_pins_s pinRaw;
  vsb_pins_s pinLvl;
  vsb_pins_s pinRise;
  vsb_pins_s pinFall;

  assign pinRaw = '{videoClock: videoClock, serialClock: serialClock,
                    hsync: hsyncIn, vsync: vsyncIn, composite_sync: csyncIn};

  vsb_sync_edge #(.W(`VSB_PIN_N)) uSync (
    .clock (clock),
    .srst  (srst),
    .din   (pinRaw),
    .lvl   (pinLvl),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file and bus slave
  logic [`VSB_DPY_W-1:0] dpy_reg;
  logic [`VSB_DPY_W-1:0] dpy_next;
  logic [CNT_W-1:0]      tmg_reg [8];
  logic [CNT_W-1:0]      tmg_next [8];
  logic [CNT_W-1:0]      hPre_reg;
  logic [CNT_W-1:0]      hPre_next;
  logic [CNT_W-1:0]      vPre_reg;
  logic [CNT_W-1:0]      vPre_next;
  logic [CNT_W-1:0]      serLim_reg;
  logic [CNT_W-1:0]      serLim_next;
  logic                  wrPend_reg;
  logic                  wrPend_next;
  logic [7:0]            wrAddr_reg;
  logic [7:0]            wrAddr_next;
  logic [31:0]           rdata_reg;
  logic [31:0]           rdata_next;
  logic                  addrPhase;
  logic [CNT_W-1:0]      horizontal_counter_reg;
  logic [CNT_W-1:0]      vertical_counter_reg;
  logic [CNT_W-1:0]      serCount_reg;
  logic [1:0]            hPh;
  logic [1:0]            vPh;

  assign addrPhase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // writes land in data phase, reads see the pending write
  always_comb begin
    dpy_next    = dpy_reg;
    tmg_next    = tmg_reg;
    hPre_next   = hPre_reg;
    vPre_next   = vPre_reg;
    serLim_next = serLim_reg;
    wrPend_next = addrPhase && hwrite && (hsize == 3'h2);
    wrAddr_next = haddr[7:0];
    rdata_next  = rdata_reg;
    if (wrPend_reg) begin
      case (wrAddr_reg)
        `VSB_OFS_DISPLAY_CONTROL_REG:  dpy_next    = hwdata[`VSB_DPY_W-1:0];
        `VSB_OFS_HPRESET: hPre_next   = hwdata[CNT_W-1:0];
        `VSB_OFS_VPRESET: vPre_next   = hwdata[CNT_W-1:0];
        `VSB_OFS_SERLIM:  serLim_next = hwdata[CNT_W-1:0];
        default: begin
          if (wrAddr_reg >= `VSB_OFS_TMG_BASE && wrAddr_reg < `VSB_OFS_HPRESET
              && wrAddr_reg[1:0] == 2'h0) begin
            tmg_next[3'(wrAddr_reg[4:2] - 3'h1)] = hwdata[CNT_W-1:0];
          end
        end
      endcase
    end
    if (addrPhase && !hwrite) begin
      rdata_next = 32'h0000_0000;
      case (haddr[7:0])
        `VSB_OFS_DISPLAY_CONTROL_REG:  rdata_next[`VSB_DPY_W-1:0] = dpy_next;
        `VSB_OFS_HPRESET: rdata_next[CNT_W-1:0]      = hPre_next;
        `VSB_OFS_VPRESET: rdata_next[CNT_W-1:0]      = vPre_next;
        `VSB_OFS_SERLIM:  rdata_next[CNT_W-1:0]      = serLim_next;
        `VSB_OFS_COUNTS: begin
          rdata_next[CNT_W-1:0]     = horizontal_counter_reg;
          rdata_next[16+:CNT_W]     = vertical_counter_reg;
        end
        `VSB_OFS_SERSTAT: begin
          rdata_next[CNT_W-1:0]     = serCount_reg;
          rdata_next[31:28]         = {hPh, vPh};
        end
        default: begin
          if (haddr[7:0] >= `VSB_OFS_TMG_BASE && haddr[7:0] < `VSB_OFS_HPRESET
              && haddr[1:0] == 2'h0) begin
            rdata_next[CNT_W-1:0] = tmg_next[3'(haddr[4:2] - 3'h1)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dpy_reg    <= `VSB_DPY_RESET;
      tmg_reg    <= '{default: '0};
      hPre_reg   <= '0;
      vPre_reg   <= '0;
      serLim_reg <= '0;
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      dpy_reg    <= dpy_next;
      tmg_reg    <= tmg_next;
      hPre_reg   <= hPre_next;
      vPre_reg   <= vPre_next;
      serLim_reg <= serLim_next;
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      rdata_reg  <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin direction control
  logic compMode;
  logic csyncDrive;
  logic hsyncDrive;
  logic vsyncDrive;

  assign compMode   = dpy_reg[`VSB_DPY_COMP_MODE];
  assign csyncDrive = !compMode || dpy_reg[`VSB_DPY_COMPOSITE_SYNC_OUT];
  assign hsyncDrive = dpy_reg[`VSB_DPY_HSYNC_OUT];
  assign vsyncDrive = dpy_reg[`VSB_DPY_VSYNC_OUT];
  assign csyncOeN   = !csyncDrive;
  assign hsyncOeN   = !hsyncDrive;
  assign vsyncOeN   = !vsyncDrive;

  ////////////////////////////////////////////////////////////////////////////
  // video timing, advanced once per rising video clock edge
  logic             vTick;
  logic             hEvt;
  logic             vEvt;
  logic             csVdet;
  logic             lineEnd;
  vsb_cs_e          cs_reg;
  vsb_cs_e          cs_next;
  logic [VD_W-1:0]  csCnt_reg;
  logic [VD_W-1:0]  csCnt_next;
  logic             hPend_reg;
  logic             hPend_next;
  logic             vPend_reg;
  logic             vPend_next;
  logic [CNT_W-1:0] horizontal_counter_next;
  logic [CNT_W-1:0] vertical_counter_next;

  assign vTick   = pinRise.videoClock;
  assign hPh     = tmgPhase(horizontal_counter_reg, tmg_reg[0], tmg_reg[1], tmg_reg[2]);
  assign vPh     = tmgPhase(vertical_counter_reg, tmg_reg[4], tmg_reg[5], tmg_reg[6]);
  assign lineEnd = horizontal_counter_reg >= tmg_reg[`VSB_TMG_TOTAL];
  assign csVdet  = vTick && (cs_reg == CS_LOW)
                   && (csCnt_reg == VD_W'(VDET_TICKS));
  assign hEvt = (!hsyncDrive && pinFall.hsync)
                || (compMode && !csyncDrive && pinFall.composite_sync);
  assign vEvt = (!vsyncDrive && pinFall.vsync) || csVdet;

  always_comb begin
    cs_next     = cs_reg;
    csCnt_next  = csCnt_reg;
    horizontal_counter_next = horizontal_counter_reg;
    vertical_counter_next = vertical_counter_reg;
    // set wins over the tick that consumes a pending load
    hPend_next  = hEvt || (hPend_reg && !vTick);
    vPend_next  = vEvt || (vPend_reg && !vTick);
    // long composite low means vertical sync
    case (cs_reg)
      CS_HIGH: begin
        csCnt_next = '0;
        if (compMode && !csyncDrive && !pinLvl.composite_sync) begin
          cs_next = CS_LOW;
        end
      end
      CS_LOW: begin
        if (pinLvl.composite_sync || csyncDrive) begin
          cs_next = CS_HIGH;
        end else if (csVdet) begin
          cs_next = CS_VSYNC;
        end else if (vTick) begin
          csCnt_next = VD_W'(csCnt_reg + 1'b1);
        end
      end
      CS_VSYNC: begin
        if (pinLvl.composite_sync || csyncDrive) begin
          cs_next = CS_HIGH;
        end
      end
      default: cs_next = CS_HIGH;
    endcase
    if (vTick) begin
      if (hPend_reg) begin
        horizontal_counter_next = hPre_reg;
      end else if (lineEnd) begin
        horizontal_counter_next = '0;
      end else begin
        horizontal_counter_next = CNT_W'(horizontal_counter_reg + 1'b1);
      end
      if (vPend_reg) begin
        vertical_counter_next = vPre_reg;
      end else if (lineEnd && !hPend_reg) begin
        if (vertical_counter_reg >= tmg_reg[`VSB_TMG_VERT + `VSB_TMG_TOTAL]) begin
          vertical_counter_next = '0;
        end else begin
          vertical_counter_next = CNT_W'(vertical_counter_reg + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cs_reg     <= CS_HIGH;
      csCnt_reg  <= '0;
      hPend_reg  <= 1'b0;
      vPend_reg  <= 1'b0;
      horizontal_counter_reg <= '0;
      vertical_counter_reg <= '0;
    end else begin
      cs_reg     <= cs_next;
      csCnt_reg  <= csCnt_next;
      hPend_reg  <= hPend_next;
      vPend_reg  <= vPend_next;
      horizontal_counter_reg <= horizontal_counter_next;
      vertical_counter_reg <= vertical_counter_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs, serial tracking and vram requests
  logic             out_next_h;
  logic             out_next_v;
  logic             out_next_c;
  logic             blank_next;
  logic             xfer_next;
  logic             mid_next;
  logic [CNT_W-1:0] serCount_next;

  always_comb begin
    out_next_h = !hPh[1];
    out_next_v = !vPh[1];
    // composite from external pins or timers
    if (dpy_reg[`VSB_DPY_COMPOSITE_SYNC_EXT]) begin
      out_next_c = pinLvl.hsync && pinLvl.vsync;
    end else begin
      out_next_c = !(hPh[1] || vPh[1]);
    end
    if (!compMode) begin
      out_next_c = hPh[0];
    end
    blank_next = compMode ? (hPh[0] || vPh[0]) : vPh[0];
    xfer_next     = vTick && (horizontal_counter_reg == tmg_reg[`VSB_TMG_START_BLANK]) && !vPh[0];
    mid_next      = 1'b0;
    serCount_next = serCount_reg;
    if (xfer_next) begin
      serCount_next = '0;
    end else if (pinRise.serialClock) begin
      serCount_next = CNT_W'(serCount_reg + 1'b1);
      mid_next      = (serLim_reg != '0) && (serCount_next == serLim_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hsyncOut       <= 1'b1;
      vsyncOut       <= 1'b1;
      csyncOut       <= 1'b1;
      compositeBlank <= 1'b0;
      transferReq    <= 1'b0;
      midlineReq     <= 1'b0;
      serCount_reg   <= '0;
    end else begin
      hsyncOut       <= out_next_h;
      vsyncOut       <= out_next_v;
      csyncOut       <= out_next_c;
      compositeBlank <= blank_next;
      transferReq    <= xfer_next;
      midlineReq     <= mid_next;
      serCount_reg   <= serCount_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_hLoadTick;
    hPend_reg && vTick;
  endsequence

  property p_rst_dirs;
    $past(srst) |-> (compMode && csyncOeN && hsyncOeN && vsyncOeN);
  endproperty
  a_rst_dirs: assert property (p_rst_dirs) else $error("reset direction wrong");

  property p_blank_sep;
    !compMode ##1 !compMode |-> (compositeBlank == $past(vPh[0]));
  endproperty
  a_blank_sep: assert property (p_blank_sep) else $error("separate blank wrong");

  property p_blank_comp;
    compMode ##1 compMode |-> (compositeBlank == ($past(hPh[0]) || $past(vPh[0])));
  endproperty
  a_blank_comp: assert property (p_blank_comp) else $error("composite blank wrong");

  property p_composite_sync_dir;
    (compMode && !dpy_reg[`VSB_DPY_COMPOSITE_SYNC_OUT]) |-> csyncOeN;
  endproperty
  a_composite_sync_dir: assert property (p_composite_sync_dir) else $error("composite_sync direction wrong");

  property p_hblank_pin;
    !compMode ##1 !compMode |-> (!csyncOeN && csyncOut == $past(hPh[0]));
  endproperty
  a_hblank_pin: assert property (p_hblank_pin) else $error("hblank pin wrong");

  property p_composite_sync_int;
    (compMode && !dpy_reg[`VSB_DPY_COMPOSITE_SYNC_EXT] && hPh[1]) |=> !csyncOut;
  endproperty
  a_composite_sync_int: assert property (p_composite_sync_int) else $error("composite_sync not low");

  property p_hsync_out;
    hPh[1] |=> !hsyncOut;
  endproperty
  a_hsync_out: assert property (p_hsync_out) else $error("hsync not low");

  property p_hload;
    s_hLoadTick |=> (horizontal_counter_reg == $past(hPre_reg));
  endproperty
  a_hload: assert property (p_hload) else $error("h preset not loaded");

  property p_vload;
    (vPend_reg && vTick) |=> (vertical_counter_reg == $past(vPre_reg));
  endproperty
  a_vload: assert property (p_vload) else $error("v preset not loaded");

  property p_hold_no_tick;
    !vTick |=> ($stable(horizontal_counter_reg) && $stable(vertical_counter_reg));
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("count moved");

  property p_ser_count;
    (pinRise.serialClock && !xfer_next) |=> (serCount_reg == CNT_W'($past(serCount_reg) + 1'b1));
  endproperty
  a_ser_count: assert property (p_ser_count) else $error("serial count wrong");

endmodule

// ### verilog/vsb_map.svh
`ifndef VSB_MAP_SVH
`define VSB_MAP_SVH

// register byte offsets on the bus
`define VSB_OFS_DISPLAY_CONTROL_REG   8'h00
`define VSB_OFS_TMG_BASE 8'h04
`define VSB_OFS_HPRESET  8'h24
`define VSB_OFS_VPRESET  8'h28
`define VSB_OFS_SERLIM   8'h2C
`define VSB_OFS_COUNTS   8'h30
`define VSB_OFS_SERSTAT  8'h34

// timing register slots, horizontal then vertical
`define VSB_TMG_END_SYNC    3'h0
`define VSB_TMG_END_BLANK   3'h1
`define VSB_TMG_START_BLANK 3'h2
`define VSB_TMG_TOTAL       3'h3
`define VSB_TMG_VERT        3'h4

// display_control_reg fields
`define VSB_DPY_W          5
`define VSB_DPY_COMP_MODE  0
`define VSB_DPY_COMPOSITE_SYNC_OUT  1
`define VSB_DPY_HSYNC_OUT  2
`define VSB_DPY_VSYNC_OUT  3
`define VSB_DPY_COMPOSITE_SYNC_EXT  4
`define VSB_DPY_RESET      5'h01

// pin bundle width in bits
`define VSB_PIN_N 5

`endif

// ### verilog/vsb_pkg.sv
package vsb_pkg;

  // sampled external pins, one bit each
  typedef struct packed {
    logic videoClock;
    logic serialClock;
    logic hsync;
    logic vsync;
    logic composite_sync;
  } vsb_pins_s;

  // composite sync pulse width tracking
  typedef enum logic [1:0] {
    CS_HIGH,
    CS_LOW,
    CS_VSYNC
  } vsb_cs_e;

endpackage

// ### verilog/vsb_sync_edge.sv
`timescale 1ns/100ps

module vsb_sync_edge #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         srst,
  // asynchronous inputs
  input  wire logic [W-1:0] din,
  // synchronised level and edges
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] s1_next;
  logic [W-1:0] s2_next;
  logic [W-1:0] s3_next;

  ////////////////////////////////////////////////////////////////////////////
  // two stage synchroniser plus history flop
  // two flops first
  always_comb begin
    s1_next = din;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  // edges only from synchronised stages
  assign lvl  = s2_reg;
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised level lags the pin by two edges
  property p_sync_delay;
    @(posedge clock) disable iff (srst)
      (!$past(srst) && !$past(srst, 2)) |-> (s2_reg == $past(din, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync lag wrong");

endmodule

// ### verification/vsb_video_src.sv
`timescale 1ns/100ps

// external video source: link clocks and sync drivers
module vsb_video_src (
  // link clocks, still unless a task runs them
  output logic videoClock,
  output logic serialClock,
  // sync drivers, released high like a pulled-up pin
  output logic hDrv,
  output logic vDrv,
  output logic cDrv
);

  ////////////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    videoClock = 1'b0;
    serialClock = 1'b0;
    hDrv = 1'b1;
    vDrv = 1'b1;
    cDrv = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // video clock supplied here
  // n periods of 200 ns, then the clock stands low
  task automatic run_ticks(input int n);
    repeat (n) begin
      #100 videoClock <= 1'b1;
      #100 videoClock <= 1'b0;
    end
  endtask

  // serial clock unrelated in phase
  // n pulses at a rate unrelated to either clock
  task automatic sclk(input int n);
    repeat (n) begin
      #37 serialClock <= 1'b1;
      #37 serialClock <= 1'b0;
    end
  endtask

  // active-low sync levels as {h, v, c}
  task automatic drive(input logic [2:0] lvl);
    {hDrv, vDrv, cDrv} <= lvl;
  endtask

endmodule

// ### verification/video_sync_blank_pins_tb_top.sv
`timescale 1ns/100ps

// self-checking bench for the sync and blank pin block
module video_sync_blank_pins_tb_top;

  logic        clock;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        videoClock;
  logic        serialClock;
  logic        hDrv;
  logic        vDrv;
  logic        cDrv;
  logic        hsyncOut;
  logic        hsyncOeN;
  logic        vsyncOut;
  logic        vsyncOeN;
  logic        csyncOut;
  logic        csyncOeN;
  logic        compositeBlank;
  logic        transferReq;
  logic        midlineReq;
  wire         hsyncIn;
  wire         vsyncIn;
  wire         csyncIn;
  int          n_mismatch;
  int          checks;
  int          cyc;
  int          n;
  int          k;
  logic [31:0] rd;
  logic [11:0] k0;
  logic [11:0] tmg [8] = '{12'd2, 12'd4, 12'd12, 12'd15, 12'd1, 12'd2, 12'd6, 12'd7};

  ////////////////////////////////////////////////////////////////////////////////
  // pin levels: device value while it drives, else the source
  assign hsyncIn = hsyncOeN ? hDrv : hsyncOut;
  assign vsyncIn = vsyncOeN ? vDrv : vsyncOut;
  assign csyncIn = csyncOeN ? cDrv : csyncOut;
  assign hready  = hreadyout;

  vsb_sync_blank #(.CNT_W(12), .VDET_TICKS(4)) vsb_sync_blank_inst (
    .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .videoClock(videoClock), .serialClock(serialClock),
    .hsyncIn(hsyncIn), .hsyncOut(hsyncOut), .hsyncOeN(hsyncOeN),
    .vsyncIn(vsyncIn), .vsyncOut(vsyncOut), .vsyncOeN(vsyncOeN),
    .csyncIn(csyncIn), .csyncOut(csyncOut), .csyncOeN(csyncOeN),
    .compositeBlank(compositeBlank), .transferReq(transferReq), .midlineReq(midlineReq)
  );

  vsb_video_src vsb_video_src_inst (
    .videoClock(videoClock), .serialClock(serialClock),
    .hDrv(hDrv), .vDrv(vDrv), .cDrv(cDrv)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one ahb-lite single word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // output enables as {h, v, c}
  function automatic logic [31:0] oe();
    return {29'h0, hsyncOeN, vsyncOeN, csyncOeN};
  endfunction

  // counters report and verdict
  task automatic end_sim();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    // reset state and register access
    xfer(1'b0, 8'h00, 32'h0);
    chk(oe(), 32'h7);
    chk(rd, 32'h1);
    xfer(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    for (k = 0; k < 8; k++) xfer(1'b1, 8'h04 + 8'(k * 4), {20'h0, tmg[k]});
    xfer(1'b1, 8'h24, 32'h5);
    xfer(1'b1, 8'h28, 32'h3);
    xfer(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h5);
    // narrow write is ignored, response stays okay
    hsize <= 3'h0;
    xfer(1'b1, 8'h24, 32'h9);
    hsize <= 3'h2;
    xfer(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h5);
    chk({31'h0, hresp}, 32'h0);
    // external horizontal sync presets the horizontal count
    vsb_video_src_inst.drive(3'b011);
    repeat (10) @(posedge clock);
    vsb_video_src_inst.drive(3'b111);
    vsb_video_src_inst.run_ticks(1);
    repeat (10) @(posedge clock);
    xfer(1'b0, 8'h30, 32'h0);
    chk({20'h0, rd[11:0]}, 32'h5);
    // external vertical sync presets the vertical count
    vsb_video_src_inst.drive(3'b101);
    repeat (10) @(posedge clock);
    vsb_video_src_inst.drive(3'b111);
    vsb_video_src_inst.run_ticks(1);
    repeat (10) @(posedge clock);
    xfer(1'b0, 8'h30, 32'h0);
    chk({20'h0, rd[27:16]}, 32'h3);
    // composite input: fall loads h, long low loads v
    xfer(1'b1, 8'h28, 32'h2);
    vsb_video_src_inst.drive(3'b110);
    repeat (10) @(posedge clock);
    vsb_video_src_inst.run_ticks(1);
    repeat (10) @(posedge clock);
    xfer(1'b0, 8'h30, 32'h0);
    chk({20'h0, rd[11:0]}, 32'h5);
    vsb_video_src_inst.run_ticks(5);
    vsb_video_src_inst.drive(3'b111);
    repeat (10) @(posedge clock);
    xfer(1'b0, 8'h30, 32'h0);
    chk({20'h0, rd[27:16]}, 32'h2);
    // serial clock counting and midline request
    xfer(1'b0, 8'h34, 32'h0);
    k0 = rd[11:0];
    vsb_video_src_inst.sclk(5);
    repeat (10) @(posedge clock);
    xfer(1'b0, 8'h34, 32'h0);
    chk({20'h0, rd[11:0]}, {20'h0, k0 + 12'd5});
    xfer(1'b1, 8'h2C, {20'h0, k0 + 12'd8});
    n = 0;
    fork
      vsb_video_src_inst.sclk(3);
      repeat (60) @(posedge clock) if (midlineReq === 1'b1) n++;
    join
    chk(n, 1);
    xfer(1'b1, 8'h2C, 32'h0);
    // free-running video clock from here on
    fork
      vsb_video_src_inst.run_ticks(1300);
    join_none
    xfer(1'b1, 8'h00, 32'hD);
    @(posedge clock);
    chk(oe(), 32'h1);
    n = 0;
    while (hsyncOut !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    k = 0;
    while (hsyncOut === 1'b0 && k < 400) begin
      @(posedge clock);
      k++;
      if (k == 12) chk({31'h0, compositeBlank}, 32'h1);
    end
    chk((k + 4) / 8, 3);
    n = 0;
    while (vsyncOut !== 1'b0 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    k = 0;
    while (vsyncOut === 1'b0 && k < 2000) begin
      @(posedge clock);
      k++;
    end
    chk((k + 64) / 128, 2);
    n = 0;
    while (transferReq !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk(n < 300, 1);
    // composite output from the internal timers
    xfer(1'b1, 8'h00, 32'h3);
    @(posedge clock);
    chk(oe(), 32'h6);
    n = 0;
    while (csyncOut !== 1'b0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk(n < 300, 1);
    // composite output built from the external sync pins
    xfer(1'b1, 8'h00, 32'h13);
    @(posedge clock);
    vsb_video_src_inst.drive(3'b011);
    repeat (6) @(posedge clock);
    chk({31'h0, csyncOut}, 32'h0);
    vsb_video_src_inst.drive(3'b111);
    repeat (6) @(posedge clock);
    chk({31'h0, csyncOut}, 32'h1);
    // separate mode: shared pin is horizontal blank only
    xfer(1'b1, 8'h00, 32'hC);
    @(posedge clock);
    chk(oe(), 32'h0);
    n = 0;
    repeat (1100) @(posedge clock) if (csyncOut === 1'b1 && compositeBlank === 1'b0) n++;
    chk(n > 0, 1);
    // reset again mid-run: pins back to inputs, composite blank
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    xfer(1'b0, 8'h00, 32'h0);
    chk(oe(), 32'h7);
    chk(rd, 32'h1);
    end_sim();
  end

endmodule
